/* File: rtl/dcs_defs.svh */
// dcs_defs.svh: constants for the double-data-rate common-io sram port
// assumes inclusion by bare name from files under rtl/
`ifndef DCS_DEFS_SVH
`define DCS_DEFS_SVH

// bus and array geometry
`define DCS_DATA_W 36
`define DCS_HALF_W 18
`define DCS_ADDR_W 20
`define DCS_IDX_W 21
`define DCS_MEM_DEPTH 2097152
`define DCS_HIST_W 5

// dll lock counter width and default lock time in input clock cycles
`define DCS_LOCK_W 16
`define DCS_LOCK_CYC_DEF 2048
// highest input clock rate with the dll bypassed
`define DCS_DLL_OFF_FMAX_MHZ 167

// burst word numbers
`define DCS_WORD0 2'h0
`define DCS_WORD1 2'h1
`define DCS_WORD2 2'h2
`define DCS_WORD3 2'h3

// command history taps, dll running: 2.5 cycle read latency
`define DCS_TAP_ON_W0 2
`define DCS_TAP_ON_W1 2
`define DCS_TAP_ON_W2 3
`define DCS_TAP_ON_W3 3
// command history taps, dll bypassed, one cycle read latency
`define DCS_TAP_OFF_W0 0
`define DCS_TAP_OFF_W1 1
`define DCS_TAP_OFF_W2 1
`define DCS_TAP_OFF_W3 2
// late write: capture taps and array commit taps
`define DCS_TAP_WR_W0 0
`define DCS_TAP_WR_W1 1
`define DCS_TAP_WR_W2 1
`define DCS_TAP_WR_W3 2
`define DCS_TAP_COMMIT0 1
`define DCS_TAP_COMMIT1 2
// deepest history tap still set while the rising phase register drives a read word
`define DCS_TAP_LAST 4

`endif

/* File: rtl/dcs_pkg.sv */
// dcs_pkg: types shared by the sram port
// assumes nothing beyond a systemverilog compiler
package dcs_pkg;
    // dll state, one-hot
    typedef enum logic [2:0] {
        DCS_DLL_BYPASS = 3'h1,
        DCS_DLL_ACQUIRE = 3'h2,
        DCS_DLL_LOCKED = 3'h4
    } dcs_dll_state_t;
endpackage

/* File: rtl/dcs_sram_port.sv */
// dcs_sram_port: pin-level model of a ddr common-io burst-of-four static memory
// assumes the controller drives inputClkTrue free running and every pin synchronous to it
// Function
// RULE1 - address, load and read/write select are taken on rising input clock only
// RULE2 - write data is taken on both input phases, two words per cycle
// RULE3 - controller keeps the inverted phase half a period off, both toggling
// RULE4 - echo strobes run continuously, also while data lines float
// RULE5 - echo strobe edges line up with read data transitions
// RULE6 - dll bypass input low bypasses the dll and drops lock
// RULE7 - dll bypass input high runs the dll, locked after the lock time
// RULE8 - with dll off read latency is one cycle, clock at most 167 MHz
// RULE9 - output valid flag marks read data, aligned with echo strobes
// RULE10 - address is registered on rising clock and ignored when not loaded
// RULE11 - data lines driven only during reads, received during writes
// RULE12 - narrow organisation uses 18 data lines, wide uses all 36
// RULE13 - with load low, select high means read and low means write
// RULE14 - controller pulls load low in each cycle starting an operation
// RULE15 - dll on: first read word at 2.5 cycles, next at 3 cycles
// RULE16 - write words start one cycle after the command, burst of four
// RULE17 - load high is a no-op that leaves a running read burst intact
// RULE18 - controller floats the bus one cycle before driving write data
// RULE19 - controller issues loads at most every other rising clock
`include "dcs_defs.svh"

module dcs_sram_port #(
    parameter bit WIDE_ORG = 1'b1,
    parameter logic [`DCS_LOCK_W-1:0] DLL_LOCK_CYC = `DCS_LOCK_W'(`DCS_LOCK_CYC_DEF)
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic inputClkTrue,
    input wire logic [`DCS_ADDR_W-1:0] addressInputs,
    input wire logic loadCycleN,
    input wire logic readWriteSel,
    input wire logic dllOffN,
    input wire logic [`DCS_DATA_W-1:0] dataLinesIn,
    output logic [`DCS_DATA_W-1:0] dataLinesOut,
    output logic [`DCS_DATA_W-1:0] dataLinesOe,
    output logic echoStrobeTrue,
    output logic echoStrobeInverted,
    output logic outputValidFlag,
    output logic dllLockedSys,
    output logic readSeenSys,
    output logic writeSeenSys
);

    localparam logic [`DCS_DATA_W-1:0] USED_MASK = WIDE_ORG ? {`DCS_DATA_W{1'b1}} :
        {{`DCS_HALF_W{1'b0}}, {`DCS_HALF_W{1'b1}}};

    logic linkRstMeta_q, linkRstN_q;
    logic dllOffMeta_q, dllOffSync_q;
    dcs_pkg::dcs_dll_state_t dllState_q;
    logic [`DCS_LOCK_W-1:0] lockCnt_q;
    logic dllLocked_q, dllRun;
    logic rdIssue, wrIssue;
    logic [`DCS_HIST_W-1:0] rdHist_q, wrHist_q;
    logic [`DCS_ADDR_W-1:0] addrPipe_q [`DCS_HIST_W];
    logic [`DCS_DATA_W-1:0] wrLo_q, wrFall_q;
    logic commit, commitPair;
    logic [`DCS_ADDR_W-1:0] commitAddr;
    logic riseOe_q, fallOe_q;
    logic [`DCS_DATA_W-1:0] riseData_q, fallData_q;
    logic riseTog_q, fallTog_q;
    logic rdTog_q, wrTog_q;
    logic [2:0] rdSync_q, wrSync_q;
    logic [1:0] lockSync_q;
    bit [`DCS_DATA_W-1:0] memArray [`DCS_MEM_DEPTH];

    // array entry of a burst word; narrow words pair into one entry
    function automatic logic [`DCS_IDX_W-1:0] entryIdx(input logic [`DCS_ADDR_W-1:0] a,
                                                        input logic [1:0] k);
        if (WIDE_ORG) begin
            entryIdx = {a[`DCS_ADDR_W-2:0], k};
        end else begin
            entryIdx = {a, k[1]};
        end
    endfunction

    // one burst word read out of the array, narrow data in the low lines
    function automatic logic [`DCS_DATA_W-1:0] fetchWord(input logic [`DCS_ADDR_W-1:0] a,
                                                         input logic [1:0] k);
        logic [`DCS_DATA_W-1:0] e;
        e = memArray[entryIdx(a, k)];
        if (WIDE_ORG) begin
            fetchWord = e;
        end else if (k[0]) begin
            fetchWord = {{`DCS_HALF_W{1'b0}}, e[`DCS_DATA_W-1:`DCS_HALF_W]};
        end else begin
            fetchWord = {{`DCS_HALF_W{1'b0}}, e[`DCS_HALF_W-1:0]};
        end
    endfunction

    // reset into the link domain
    always_ff @(posedge inputClkTrue) begin
        linkRstMeta_q <= nrst;
        linkRstN_q <= linkRstMeta_q;
    end

    // dll bypass pin synchroniser
    always_ff @(posedge inputClkTrue) begin
        dllOffMeta_q <= dllOffN;
        dllOffSync_q <= dllOffMeta_q;
    end

    // RULE6 RULE7 dll bypass, lock
    always_ff @(posedge inputClkTrue) begin
        if (!linkRstN_q || !dllOffSync_q) begin
            dllState_q <= dcs_pkg::DCS_DLL_BYPASS;
            lockCnt_q <= '0;
        end else begin
            unique case (dllState_q)
                dcs_pkg::DCS_DLL_BYPASS: begin
                    dllState_q <= dcs_pkg::DCS_DLL_ACQUIRE;
                    lockCnt_q <= '0;
                end
                dcs_pkg::DCS_DLL_ACQUIRE: begin
                    if (lockCnt_q == DLL_LOCK_CYC - 1'b1) begin
                        dllState_q <= dcs_pkg::DCS_DLL_LOCKED;
                    end
                    lockCnt_q <= lockCnt_q + 1'b1;
                end
                dcs_pkg::DCS_DLL_LOCKED: begin
                    lockCnt_q <= lockCnt_q;
                end
                default: begin
                    dllState_q <= dcs_pkg::DCS_DLL_BYPASS;
                    lockCnt_q <= '0;
                end
            endcase
        end
    end

    // registered lock level for the crossing
    always_ff @(posedge inputClkTrue) begin
        dllLocked_q <= linkRstN_q && (dllState_q == dcs_pkg::DCS_DLL_LOCKED);
    end

    // RULE8 latency choice
    assign dllRun = (dllState_q != dcs_pkg::DCS_DLL_BYPASS);

    // RULE13 access type
    assign rdIssue = !loadCycleN && readWriteSel;
    assign wrIssue = !loadCycleN && !readWriteSel;

    // RULE1 command history
    always_ff @(posedge inputClkTrue) begin
        if (!linkRstN_q) begin
            rdHist_q <= '0;
            wrHist_q <= '0;
        end else begin
            rdHist_q <= {rdHist_q[`DCS_HIST_W-2:0], rdIssue};
            wrHist_q <= {wrHist_q[`DCS_HIST_W-2:0], wrIssue};
        end
    end

    // RULE10 address pipe, first stage cleared in reset and held when not loaded
    always_ff @(posedge inputClkTrue) begin
        addrPipe_q[0] <= !linkRstN_q ? '0 : (loadCycleN ? addrPipe_q[0] : addressInputs);
        for (int i = 1; i < `DCS_HIST_W; i++) begin
            addrPipe_q[i] <= addrPipe_q[i-1];
        end
    end

    // RULE2 late write, rising phase words
    always_ff @(posedge inputClkTrue) begin
        if (wrHist_q[`DCS_TAP_WR_W0] || wrHist_q[`DCS_TAP_WR_W2]) begin
            wrLo_q <= dataLinesIn;
        end
    end

    // RULE2 late write, inverted phase words
    always_ff @(negedge inputClkTrue) begin
        if (wrHist_q[`DCS_TAP_WR_W1] || wrHist_q[`DCS_TAP_WR_W3]) begin
            wrFall_q <= dataLinesIn;
        end
    end

    // word pair commit: older burst takes the second pair
    assign commitPair = wrHist_q[`DCS_TAP_COMMIT1];
    assign commit = wrHist_q[`DCS_TAP_COMMIT0] || commitPair;
    assign commitAddr = commitPair ? addrPipe_q[`DCS_TAP_COMMIT1] : addrPipe_q[`DCS_TAP_COMMIT0];

    // RULE12 array write, pair per rising clock
    always_ff @(posedge inputClkTrue) begin
        if (commit) begin
            if (WIDE_ORG) begin
                memArray[entryIdx(commitAddr, {commitPair, 1'b0})] <= wrLo_q;
                memArray[entryIdx(commitAddr, {commitPair, 1'b1})] <= wrFall_q;
            end else begin
                memArray[entryIdx(commitAddr, {commitPair, 1'b0})] <=
                    {wrFall_q[`DCS_HALF_W-1:0], wrLo_q[`DCS_HALF_W-1:0]};
            end
        end
    end

    // RULE15 RULE8 read words on the rising phase
    always_ff @(posedge inputClkTrue) begin
        if (!linkRstN_q) begin
            riseOe_q <= 1'b0;
            riseData_q <= '0;
        end else if (dllRun && rdHist_q[`DCS_TAP_ON_W3]) begin
            riseOe_q <= 1'b1;
            riseData_q <= fetchWord(addrPipe_q[`DCS_TAP_ON_W3], `DCS_WORD3);
        end else if (dllRun && rdHist_q[`DCS_TAP_ON_W1]) begin
            riseOe_q <= 1'b1;
            riseData_q <= fetchWord(addrPipe_q[`DCS_TAP_ON_W1], `DCS_WORD1);
        end else if (!dllRun && rdHist_q[`DCS_TAP_OFF_W2]) begin
            riseOe_q <= 1'b1;
            riseData_q <= fetchWord(addrPipe_q[`DCS_TAP_OFF_W2], `DCS_WORD2);
        end else if (!dllRun && rdHist_q[`DCS_TAP_OFF_W0]) begin
            riseOe_q <= 1'b1;
            riseData_q <= fetchWord(addrPipe_q[`DCS_TAP_OFF_W0], `DCS_WORD0);
        end else begin
            // RULE17 drivers float once the burst ends
            riseOe_q <= 1'b0;
        end
    end

    // RULE15 RULE8 read words on the inverted phase
    always_ff @(negedge inputClkTrue) begin
        if (!linkRstN_q) begin
            fallOe_q <= 1'b0;
            fallData_q <= '0;
        end else if (dllRun && rdHist_q[`DCS_TAP_ON_W2]) begin
            fallOe_q <= 1'b1;
            fallData_q <= fetchWord(addrPipe_q[`DCS_TAP_ON_W2], `DCS_WORD2);
        end else if (dllRun && rdHist_q[`DCS_TAP_ON_W0]) begin
            fallOe_q <= 1'b1;
            fallData_q <= fetchWord(addrPipe_q[`DCS_TAP_ON_W0], `DCS_WORD0);
        end else if (!dllRun && rdHist_q[`DCS_TAP_OFF_W3]) begin
            fallOe_q <= 1'b1;
            fallData_q <= fetchWord(addrPipe_q[`DCS_TAP_OFF_W3], `DCS_WORD3);
        end else if (!dllRun && rdHist_q[`DCS_TAP_OFF_W1]) begin
            fallOe_q <= 1'b1;
            fallData_q <= fetchWord(addrPipe_q[`DCS_TAP_OFF_W1], `DCS_WORD1);
        end else begin
            fallOe_q <= 1'b0;
        end
    end

    // RULE4 echo toggles, one per phase, never gated by reads
    always_ff @(posedge inputClkTrue) begin
        riseTog_q <= linkRstN_q ? !riseTog_q : 1'b0;
    end

    always_ff @(negedge inputClkTrue) begin
        fallTog_q <= linkRstN_q ? !fallTog_q : 1'b0;
    end

    // RULE5 RULE9 RULE11 pins: echo from both phase toggles, data and valid picked by the clock level
    assign echoStrobeTrue = riseTog_q ^ fallTog_q;
    assign echoStrobeInverted = !(riseTog_q ^ fallTog_q);
    assign outputValidFlag = inputClkTrue ? riseOe_q : fallOe_q;
    assign dataLinesOut = inputClkTrue ? riseData_q : fallData_q;
    // RULE12 only the used lines are driven
    assign dataLinesOe = outputValidFlag ? USED_MASK : '0;

    // command toggles for the system side
    always_ff @(posedge inputClkTrue) begin
        if (!linkRstN_q) begin
            rdTog_q <= 1'b0;
            wrTog_q <= 1'b0;
        end else begin
            rdTog_q <= rdTog_q ^ rdIssue;
            wrTog_q <= wrTog_q ^ wrIssue;
        end
    end

    // system side: toggle and level synchronisers
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rdSync_q <= '0;
            wrSync_q <= '0;
            lockSync_q <= '0;
            readSeenSys <= 1'b0;
            writeSeenSys <= 1'b0;
            dllLockedSys <= 1'b0;
        end else begin
            rdSync_q <= {rdSync_q[1:0], rdTog_q};
            wrSync_q <= {wrSync_q[1:0], wrTog_q};
            lockSync_q <= {lockSync_q[0], dllLocked_q};
            readSeenSys <= rdSync_q[2] ^ rdSync_q[1];
            writeSeenSys <= wrSync_q[2] ^ wrSync_q[1];
            dllLockedSys <= lockSync_q[1];
        end
    end

    // checks on the link side
    property p_cmdLatch;
        @(posedge inputClkTrue) disable iff (!linkRstN_q)
        !loadCycleN |=> (addrPipe_q[0] == $past(addressInputs));
    endproperty
    a_cmdLatch: assert property (p_cmdLatch) else $error("address not taken on load"); // RULE1

    property p_idleIgnore;
        @(posedge inputClkTrue) disable iff (!linkRstN_q)
        loadCycleN |=> (!rdHist_q[0] && !wrHist_q[0] && $stable(addrPipe_q[0]));
    endproperty
    a_idleIgnore: assert property (p_idleIgnore) else $error("unloaded cycle acted"); // RULE10

    property p_accessType;
        @(posedge inputClkTrue) disable iff (!linkRstN_q)
        !loadCycleN |=> (rdHist_q[0] == $past(readWriteSel)) && (wrHist_q[0] != rdHist_q[0]);
    endproperty
    a_accessType: assert property (p_accessType) else $error("access type wrong"); // RULE13

    property p_wrRise;
        @(posedge inputClkTrue) disable iff (!linkRstN_q)
        wrIssue |-> ##2 (wrLo_q == $past(dataLinesIn));
    endproperty
    a_wrRise: assert property (p_wrRise) else $error("first write word missed"); // RULE2

    property p_wrFall;
        @(negedge inputClkTrue) disable iff (!linkRstN_q)
        wrHist_q[`DCS_TAP_WR_W1] |=> (wrFall_q == $past(dataLinesIn));
    endproperty
    a_wrFall: assert property (p_wrFall) else $error("second write word missed"); // RULE2

    property p_readDll;
        @(posedge inputClkTrue) disable iff (!linkRstN_q)
        (rdIssue && dllRun) |-> ##4 riseOe_q ##1 riseOe_q;
    endproperty
    a_readDll: assert property (p_readDll) else $error("dll read words late"); // RULE15

    property p_readNoDll;
        @(posedge inputClkTrue) disable iff (!linkRstN_q)
        (rdIssue && !dllRun && $stable(dllRun)) |-> ##2 riseOe_q;
    endproperty
    a_readNoDll: assert property (p_readNoDll) else $error("one cycle read latency broken"); // RULE8

    property p_nopKeep;
        @(posedge inputClkTrue) disable iff (!linkRstN_q)
        (rdIssue && dllRun) ##1 loadCycleN |-> ##3 riseOe_q ##1 riseOe_q;
    endproperty
    a_nopKeep: assert property (p_nopKeep) else $error("no-op cut the read burst"); // RULE17

    property p_driveOnlyRead;
        @(posedge inputClkTrue) disable iff (!linkRstN_q)
        riseOe_q |-> (|rdHist_q[`DCS_TAP_LAST:0]);
    endproperty
    a_driveOnlyRead: assert property (p_driveOnlyRead) else $error("driven without read"); // RULE11

    property p_echoRun;
        @(posedge inputClkTrue) disable iff (!linkRstN_q)
        ##1 (riseTog_q != fallTog_q) && $changed(fallTog_q);
    endproperty
    a_echoRun: assert property (p_echoRun) else $error("echo strobe stopped"); // RULE4

    property p_dllBypass;
        @(posedge inputClkTrue) disable iff (!linkRstN_q)
        !dllOffSync_q |=> (dllState_q == dcs_pkg::DCS_DLL_BYPASS) && (lockCnt_q == '0);
    endproperty
    a_dllBypass: assert property (p_dllBypass) else $error("dll not bypassed"); // RULE6

    property p_dllLock;
        @(posedge inputClkTrue) disable iff (!linkRstN_q)
        (dllState_q == dcs_pkg::DCS_DLL_ACQUIRE) && dllOffSync_q
            |=> ((dllState_q == dcs_pkg::DCS_DLL_LOCKED) == ($past(lockCnt_q) ==
                DLL_LOCK_CYC - 1'b1)) || !dllOffSync_q;
    endproperty
    a_dllLock: assert property (p_dllLock) else $error("dll lock time wrong"); // RULE7

    property p_narrowLines;
        @(posedge inputClkTrue) disable iff (!linkRstN_q)
        !WIDE_ORG |-> (dataLinesOe[`DCS_DATA_W-1:`DCS_HALF_W] == '0);
    endproperty
    a_narrowLines: assert property (p_narrowLines) else $error("upper lines driven"); // RULE12

    // main scenarios
    c_readDll: cover property (@(posedge inputClkTrue) disable iff (!linkRstN_q)
        (rdIssue && dllRun) ##4 riseOe_q);
    c_readNoDll: cover property (@(posedge inputClkTrue) disable iff (!linkRstN_q)
        (rdIssue && !dllRun) ##2 riseOe_q);
    c_write: cover property (@(posedge inputClkTrue) disable iff (!linkRstN_q)
        wrIssue ##3 commitPair);
    c_backToBack: cover property (@(posedge inputClkTrue) disable iff (!linkRstN_q)
        wrIssue ##2 rdIssue);

endmodule

/* File: sim/dcs_ctrl_model.sv */
// dcs_ctrl_model: behavioural memory controller on the far side of the sram port pins
// assumes the bench calls do_write and do_read one at a time, after reset
`include "dcs_defs.svh"

module dcs_ctrl_model (
    output logic inputClkTrue,
    output logic [`DCS_ADDR_W-1:0] addressInputs,
    output logic loadCycleN,
    output logic readWriteSel,
    output logic [`DCS_DATA_W-1:0] dataLinesIn,
    input wire logic [`DCS_DATA_W-1:0] dataLinesOut,
    input wire logic [`DCS_DATA_W-1:0] dataLinesOe,
    input wire logic echoStrobeTrue,
    input wire logic outputValidFlag
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int DW = `DCS_DATA_W;
    logic [DW-1:0] drvData = '0;
    logic drvOn = 1'b0;
    logic [DW-1:0] idlePat = 36'h5a5a5a5a5;

    initial begin
        inputClkTrue = 1'b0;
        loadCycleN = 1'b1;
        readWriteSel = 1'b0;
        addressInputs = '0;
        forever #80 inputClkTrue = ~inputClkTrue;
    end

    // floating lines show a pattern that flips on every phase
    always @(inputClkTrue) idlePat <= ~idlePat;

    // wire level of each line from both drivers, a clash reads unknown
    always_comb begin
        for (int i = 0; i < DW; i++) begin
            dataLinesIn[i] = (dataLinesOe[i] === 1'b1) ? (drvOn ? 1'bx : dataLinesOut[i])
                : (drvOn ? drvData[i] : idlePat[i]);
        end
    end

    task automatic do_write(input logic [19:0] a, input logic [3:0][DW-1:0] w);
        @(posedge inputClkTrue);
        #1 {loadCycleN, readWriteSel, addressInputs} = {1'b0, 1'b0, a};
        // command is taken on this edge, then the address is scrambled
        @(posedge inputClkTrue);
        #1 {loadCycleN, addressInputs} = {1'b1, ~a};
        for (int k = 0; k < 4; k++) begin
            if (k[0]) @(posedge inputClkTrue);
            else @(negedge inputClkTrue);
            #1 drvData = w[k];
            drvOn = 1'b1;
        end
        @(negedge inputClkTrue);
        #1 drvOn = 1'b0;
    endtask

    // read, then sample six half cycles around the burst
    task automatic do_read(input logic [19:0] a, input bit latOne,
            output logic [3:0][DW-1:0] w, output logic [5:0] vld, output logic [5:0] oeAny,
            output logic [5:0] echo, output logic [DW-1:0] oeW0);
        @(posedge inputClkTrue);
        #1 {loadCycleN, readWriteSel, addressInputs} = {1'b0, 1'b1, a};
        #160 {loadCycleN, addressInputs} = {1'b1, ~a};
        #(latOne ? 119 : 359);
        for (int s = 0; s < 6; s++) begin
            vld[5-s] = outputValidFlag;
            oeAny[5-s] = |dataLinesOe;
            echo[5-s] = echoStrobeTrue;
            if (s > 0 && s < 5) w[s-1] = dataLinesIn;
            if (s == 1) oeW0 = dataLinesOe;
            #80;
        end
    endtask
endmodule

/* File: sim/dcs_sram_port_tb.sv */
// dcs_sram_port_tb: self-checking bench for the sram port, wide and narrow copies
// assumes dcs_ctrl_model plays the controller and makes the link clock
`include "dcs_defs.svh"

module dcs_sram_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int DW = `DCS_DATA_W;
    localparam int LK = 8;
    logic sys_clk, nrst, dllOffN;
    logic kW, kN, ldW, ldN, rwW, rwN, echoTW, echoTN, echoIW, vldW, vldN, lockW, rdSW, wrSW;
    logic [19:0] adW, adN;
    logic [DW-1:0] diW, diN, doW, doN, oeW, oeN;
    int fail_count, cmp_count, rdCnt, wrCnt, rdExp, wrExp, cycCnt;

    dcs_sram_port #(.WIDE_ORG(1'b1), .DLL_LOCK_CYC(`DCS_LOCK_W'(LK))) i_dcs_sram_port (
        .sys_clk(sys_clk), .nrst(nrst), .inputClkTrue(kW), .addressInputs(adW),
        .loadCycleN(ldW), .readWriteSel(rwW), .dllOffN(dllOffN), .dataLinesIn(diW),
        .dataLinesOut(doW), .dataLinesOe(oeW), .echoStrobeTrue(echoTW),
        .echoStrobeInverted(echoIW), .outputValidFlag(vldW), .dllLockedSys(lockW),
        .readSeenSys(rdSW), .writeSeenSys(wrSW));
    dcs_ctrl_model i_dcs_ctrl_model (.inputClkTrue(kW), .addressInputs(adW),
        .loadCycleN(ldW), .readWriteSel(rwW), .dataLinesIn(diW), .dataLinesOut(doW),
        .dataLinesOe(oeW), .echoStrobeTrue(echoTW), .outputValidFlag(vldW));
    dcs_sram_port #(.WIDE_ORG(1'b0), .DLL_LOCK_CYC(`DCS_LOCK_W'(LK))) i_dcs_sram_port_n (
        .sys_clk(sys_clk), .nrst(nrst), .inputClkTrue(kN), .addressInputs(adN),
        .loadCycleN(ldN), .readWriteSel(rwN), .dllOffN(dllOffN), .dataLinesIn(diN),
        .dataLinesOut(doN), .dataLinesOe(oeN), .echoStrobeTrue(echoTN),
        .echoStrobeInverted(), .outputValidFlag(vldN), .dllLockedSys(),
        .readSeenSys(), .writeSeenSys());
    dcs_ctrl_model i_dcs_ctrl_model_n (.inputClkTrue(kN), .addressInputs(adN),
        .loadCycleN(ldN), .readWriteSel(rwN), .dataLinesIn(diN), .dataLinesOut(doN),
        .dataLinesOe(oeN), .echoStrobeTrue(echoTN), .outputValidFlag(vldN));

    // system clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // count status pulses and cut a hang short
    always @(posedge sys_clk) begin
        cycCnt++;
        if (rdSW === 1'b1) rdCnt++;
        if (wrSW === 1'b1) wrCnt++;
        if (cycCnt == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    task automatic chkW(input string n, input logic [DW-1:0] e, input logic [DW-1:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic chkF(input string n, input logic [5:0] e, input logic [5:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask

    // distinct word per low 16 address bits and burst index
    function automatic logic [DW-1:0] pat(input logic [19:0] a, input int k);
        return {a[15:0], 4'(k), 16'hc3a5 ^ (16'(k) * 16'h1111)};
    endfunction

    // read on both copies and judge words, flags, drive and echo per half cycle
    task automatic rd_chk(input logic [19:0] a, input bit latOne);
        logic [3:0][DW-1:0] w, wn;
        logic [5:0] v, vn, o, on, e, en;
        logic [DW-1:0] m, mn;
        fork
            i_dcs_ctrl_model.do_read(a, latOne, w, v, o, e, m);
            i_dcs_ctrl_model_n.do_read(a, latOne, wn, vn, on, en, mn);
        join
        rdExp++;
        for (int k = 0; k < 4; k++) begin
            chkW("word", pat(a, k), w[k]);
            chkW("nword", pat(a, k) & 36'h00003ffff, wn[k] & 36'h00003ffff);
        end
        chkF("valid", 6'h1e, v);
        chkF("nvalid", 6'h1e, vn);
        chkF("drive", 6'h1e, o);
        chkF("echo", latOne ? 6'h2a : 6'h15, e);
        chkW("oe", 36'hfffffffff, m);
        chkW("noe", 36'h00003ffff, mn);
        chkF("rdseen", 6'(rdExp), 6'(rdCnt));
    endtask

    task automatic t_lock();
        repeat (4) @(posedge kW);
        chkF("lock", 6'h0, {5'h0, lockW});
        repeat (LK + 8) @(posedge kW);
        chkF("lock", 6'h1, {5'h0, lockW});
        $display("test lock done, fails %0d", fail_count);
    endtask

    task automatic t_wr_rd();
        logic [19:0] a;
        logic [3:0][DW-1:0] w;
        for (int i = 0; i < 3; i++) begin
            a = (i == 0) ? 20'h00000 : (i == 1) ? 20'h7ffff : 20'h2c3a1;
            for (int k = 0; k < 4; k++) w[k] = pat(a, k);
            fork
                i_dcs_ctrl_model.do_write(a, w);
                i_dcs_ctrl_model_n.do_write(a, w);
            join
            wrExp++;
            rd_chk(a, 1'b0);
        end
        rd_chk(20'h00000, 1'b0);
        chkF("wrseen", 6'(wrExp), 6'(wrCnt));
        $display("test write read done, fails %0d", fail_count);
    endtask

    task automatic t_nop();
        repeat (16) begin
            @(kW);
            #40;
            chkF("nop", {3'h0, ~kW, kW, 1'b0}, {3'h0, echoTW, echoIW, vldW | (|oeW)});
        end
        chkF("rdseen", 6'(rdExp), 6'(rdCnt));
        $display("test nop done, fails %0d", fail_count);
    endtask

    task automatic t_bypass();
        @(posedge sys_clk);
        #1 dllOffN = 1'b0;
        repeat (6) @(posedge kW);
        chkF("lock", 6'h0, {5'h0, lockW});
        rd_chk(20'h7ffff, 1'b1);
        @(posedge sys_clk);
        #1 dllOffN = 1'b1;
        repeat (4) @(posedge kW);
        chkF("lock", 6'h0, {5'h0, lockW});
        rd_chk(20'h2c3a1, 1'b0);
        repeat (LK + 4) @(posedge kW);
        chkF("lock", 6'h1, {5'h0, lockW});
        $display("test bypass done, fails %0d", fail_count);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // reset long enough for the link side to see it, then the scenarios
    initial begin
        nrst = 1'b0;
        dllOffN = 1'b1;
        repeat (4) @(posedge kW);
        @(posedge sys_clk);
        #1 nrst = 1'b1;
        t_lock();
        t_wr_rd();
        t_nop();
        t_bypass();
        tally_and_finish();
    end
endmodule
